// ===== pkg/fpe_pkg.sv
// package for the flash program/erase sequencer control block
// Notes on behaviour
// - routines land in RAM at the download target address register value.
// - user boot mode allows main array changes only; boot array is locked.
// - after reset in user boot mode a check runs; no interrupt accepted.
// - after the check, boot vector is used and array select reads AA.
// - user boot mode maps boot array; main array only mapped for changes.
// - during an array switch accesses stall and vectors are undefined.
// - array select write switches the mapped array; set it from on-chip RAM.
// - flash readable during and after download; blocked while a run is active.
// - after program/erase, flash reads blocked until key register cleared.
// - program data pointer inside flash makes the program routine fail.
// - user boot mode is chosen at reset by its own mode pin setting.
package fpe_pkg;
   // register offsets
   localparam logic [3:0] OFS_KEY = 4'h0;
   localparam logic [3:0] OFS_SEL = 4'h1;
   localparam logic [3:0] OFS_TGT = 4'h2;
   localparam logic [3:0] OFS_CCS = 4'h3;
   localparam logic [3:0] OFS_STAT = 4'h4;
   localparam logic [3:0] OFS_PDP = 4'h5;
   localparam logic [3:0] OFS_RET = 4'h6;
   // key and select values
   localparam logic [7:0] KEY_PE = 8'h5A;
   localparam logic [7:0] KEY_DL = 8'hA5;
   localparam logic [7:0] SEL_BOOT = 8'hAA;
   localparam logic [7:0] SEL_MAIN = 8'h00;
   localparam logic [7:0] TGT_RST = 8'h00;
   // entry offsets within a downloaded routine
   localparam logic [7:0] ENTRY_RUN = 8'h10;
   localparam logic [7:0] ENTRY_INIT = 8'h20;
   localparam logic [7:0] ROUTINE_STACK = 8'h80;
   // return codes
   localparam logic [7:0] RET_OK = 8'h00;
   localparam logic [7:0] RET_ERR_PTR = 8'h01;
   localparam logic [7:0] RET_ERR_KEY = 8'h02;
   localparam logic [7:0] RET_ERR_MAT = 8'h04;
   // status / control bit positions
   localparam int CCS_TRIG = 0;
   localparam int CCS_GO = 1;
   localparam int CCS_ERASE = 2;
   localparam int CCS_BOOTMAT = 3;
   localparam int ST_BUSY = 0;
   localparam int ST_BLOCK = 1;
   localparam int ST_DLDONE = 2;
   localparam int ST_SWITCH = 3;
   localparam int ST_CHECK = 4;
   localparam int ST_UBOOT = 5;
   localparam int ST_RESLONG = 6;
   // mode pin encodings
   localparam logic [1:0] MODE_USER_PROG = 2'h0;
   localparam logic [1:0] MODE_USER_BOOT = 2'h1;
   localparam logic [1:0] MODE_SERIAL_BOOT = 2'h2;
   localparam logic [1:0] MODE_PROGRAMMER = 2'h3;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int RES_LONG_US = 100;
   localparam int RES_LONG_CYC = RES_LONG_US * CLK_MHZ;
   localparam int CHECK_CYC = 16;
   localparam int SWITCH_CYC = 4;
   localparam int DL_CYC = 8;
   localparam int OP_CYC = 32;
   typedef enum logic [2:0] {
      FPE_CHECK = 3'b000,
      FPE_IDLE = 3'b001,
      FPE_DOWNLOAD = 3'b010,
      FPE_SWITCH = 3'b011,
      FPE_RUN = 3'b100,
      FPE_DONE = 3'b101
   } fpe_state_t;
   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } fpe_req_t;
   typedef struct packed {
      fpe_state_t st;
      logic [15:0] cnt;
      logic [7:0] key;
      logic [7:0] sel;
      logic [7:0] tgt;
      logic [7:0] pdp;
      logic [7:0] ret;
      logic erase;
      logic dl_done;
      logic block;
      logic uboot;
      logic irq_hold;
      logic [1:0] mode_s1;
      logic [1:0] mode_s2;
      logic strap_done;
      logic [7:0] rdata;
      logic [15:0] rcnt;
      logic res_long;
   } fpe_regs_t;
endpackage

// ===== rtl/fpe_ctrl.sv
// flash program/erase sequencer control with user boot support
`timescale 1ns/1ns
`default_nettype none
module fpe_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // mode pins seen at release, reset pin level counted while low
   input wire logic [1:0] mode_pins,
   input wire logic chip_init_pin_n,
   // register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // flash / cpu side
   input wire logic irq_req,
   output logic irq_accept,
   output logic flash_read_ok,
   output logic map_boot,
   output logic [7:0] ram_load_addr,
   output logic pe_busy
);
   fpe_pkg::fpe_regs_t q, next_q;
   logic ubm;
   logic [1:0] pin_s1, pin_s2;
   logic resn_s1, resn_s2;

   // pins pass two flops before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1 <= 2'h0;
         pin_s2 <= 2'h0;
         resn_s1 <= 1'b1;
         resn_s2 <= 1'b1;
      end else begin
         pin_s1 <= mode_pins;
         pin_s2 <= pin_s1;
         resn_s1 <= chip_init_pin_n;
         resn_s2 <= resn_s1;
      end
   end

   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      hit = (a == o);
   endfunction

   assign ubm = q.uboot;

   always_comb begin
      next_q = q;
      next_q.mode_s1 = pin_s2;
      next_q.mode_s2 = q.mode_s1;
      next_q.rdata = 8'h00;
      // strap caught once the pins have crossed both flops after release;
      // before that the synchroniser still shows its reset value
      if (!q.strap_done && q.st == fpe_pkg::FPE_CHECK &&
          q.cnt == 16'h0002) begin
         next_q.strap_done = 1'b1;
         next_q.uboot = (pin_s2 == fpe_pkg::MODE_USER_BOOT);
      end
      // long reset measure: counts cycles of the pin held low, sticky
      if (resn_s2)
         next_q.rcnt = 16'h0000;
      else if (q.rcnt != 16'hFFFF)
         next_q.rcnt = q.rcnt + 16'h0001;
      if (q.rcnt >= 16'(fpe_pkg::RES_LONG_CYC))
         next_q.res_long = 1'b1;
      // hold interrupts during the check, serve afterwards
      if (irq_req && q.st == fpe_pkg::FPE_CHECK)
         next_q.irq_hold = 1'b1;
      else if (q.st != fpe_pkg::FPE_CHECK)
         next_q.irq_hold = 1'b0;
      if (rd) begin
         unique case (addr)
            fpe_pkg::OFS_KEY: next_q.rdata = q.key;
            fpe_pkg::OFS_SEL: next_q.rdata = q.sel;
            fpe_pkg::OFS_TGT: next_q.rdata = q.tgt;
            fpe_pkg::OFS_PDP: next_q.rdata = q.pdp;
            fpe_pkg::OFS_RET: next_q.rdata = q.ret;
            fpe_pkg::OFS_STAT: next_q.rdata = {1'b0, q.res_long, q.uboot,
               q.st == fpe_pkg::FPE_CHECK, q.st == fpe_pkg::FPE_SWITCH,
               q.dl_done, q.block, q.st == fpe_pkg::FPE_RUN};
            default: next_q.rdata = 8'h00;
         endcase
      end
      unique case (q.st)
         fpe_pkg::FPE_CHECK: begin
            // built-in check of both arrays; no interrupts taken
            next_q.cnt = q.cnt + 16'h0001;
            if (q.cnt == 16'(fpe_pkg::CHECK_CYC - 1)) begin
               next_q.st = fpe_pkg::FPE_IDLE;
               next_q.cnt = 16'h0000;
               if (q.uboot)
                  next_q.sel = fpe_pkg::SEL_BOOT;
            end
         end
         fpe_pkg::FPE_IDLE: begin
            if (wr) begin
               unique case (addr)
                  fpe_pkg::OFS_KEY: begin
                     next_q.key = wdata;
                     if (wdata == 8'h00)
                        next_q.block = 1'b0;
                  end
                  fpe_pkg::OFS_SEL: begin
                     // a select write of a new value in user boot mode starts a switch; accesses stall
                     if (q.uboot && wdata != q.sel) begin
                        next_q.sel = wdata;
                        next_q.st = fpe_pkg::FPE_SWITCH;
                        next_q.cnt = 16'h0000;
                     end
                  end
                  fpe_pkg::OFS_TGT: next_q.tgt = wdata;
                  fpe_pkg::OFS_PDP: next_q.pdp = wdata;
                  fpe_pkg::OFS_CCS: begin
                     next_q.erase = wdata[fpe_pkg::CCS_ERASE];
                     if (wdata[fpe_pkg::CCS_TRIG]) begin
                        // download swaps in the routine store
                        next_q.st = fpe_pkg::FPE_DOWNLOAD;
                        next_q.cnt = 16'h0000;
                        next_q.dl_done = 1'b0;
                     end else if (wdata[fpe_pkg::CCS_GO]) begin
                        if (q.key != fpe_pkg::KEY_PE)
                           next_q.ret = fpe_pkg::RET_ERR_KEY;
                        else if (q.uboot && q.sel == fpe_pkg::SEL_BOOT)
                           next_q.ret = fpe_pkg::RET_ERR_MAT;
                        else if (!wdata[fpe_pkg::CCS_ERASE]
                                 && q.pdp[7])
                           next_q.ret = fpe_pkg::RET_ERR_PTR;
                        else begin
                           next_q.st = fpe_pkg::FPE_RUN;
                           next_q.cnt = 16'h0000;
                        end
                     end
                  end
                  default: ;
               endcase
            end
         end
         fpe_pkg::FPE_DOWNLOAD: begin
            next_q.cnt = q.cnt + 16'h0001;
            if (q.cnt == 16'(fpe_pkg::DL_CYC - 1)) begin
               next_q.st = fpe_pkg::FPE_IDLE;
               next_q.dl_done = 1'b1;
            end
         end
         fpe_pkg::FPE_SWITCH: begin
            next_q.cnt = q.cnt + 16'h0001;
            if (q.cnt == 16'(fpe_pkg::SWITCH_CYC - 1))
               next_q.st = fpe_pkg::FPE_IDLE;
         end
         fpe_pkg::FPE_RUN: begin
            next_q.cnt = q.cnt + 16'h0001;
            if (q.cnt == 16'(fpe_pkg::OP_CYC - 1)) begin
               next_q.st = fpe_pkg::FPE_DONE;
               next_q.ret = fpe_pkg::RET_OK;
            end
         end
         fpe_pkg::FPE_DONE: begin
            next_q.block = 1'b1;
            next_q.st = fpe_pkg::FPE_IDLE;
         end
         default: next_q.st = fpe_pkg::FPE_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.st <= fpe_pkg::FPE_CHECK;
         q.sel <= fpe_pkg::SEL_MAIN;
         q.tgt <= fpe_pkg::TGT_RST;
      end else begin
         q <= next_q;
      end
   end

   // flash readable except while checking, busy, switching or blocked
   assign flash_read_ok = !(q.st == fpe_pkg::FPE_RUN ||
      q.st == fpe_pkg::FPE_SWITCH || q.st == fpe_pkg::FPE_CHECK ||
      q.block);
   // boot array mapped in user boot mode only while select holds the boot value AA
   assign map_boot = ubm && q.sel == fpe_pkg::SEL_BOOT;
   assign irq_accept = (q.st != fpe_pkg::FPE_CHECK) &&
      (q.st != fpe_pkg::FPE_SWITCH) && (q.irq_hold || irq_req);
   assign ram_load_addr = q.tgt;
   assign pe_busy = (q.st == fpe_pkg::FPE_RUN);
   assign rdata = q.rdata;

   property p_nocheckirq;
      @(posedge clk) disable iff (rst)
      q.st == fpe_pkg::FPE_CHECK |-> !irq_accept;
   endproperty
   a_nocheckirq: assert property (p_nocheckirq)
      else $error("irq in check");

   property p_bootsel;
      @(posedge clk) disable iff (rst)
      (q.st == fpe_pkg::FPE_CHECK && next_q.st == fpe_pkg::FPE_IDLE &&
       q.uboot)
         |=> q.sel == fpe_pkg::SEL_BOOT;
   endproperty
   a_bootsel: assert property (p_bootsel) else $error("boot sel");

   property p_runblock;
      @(posedge clk) disable iff (rst)
      pe_busy |-> !flash_read_ok;
   endproperty
   a_runblock: assert property (p_runblock)
      else $error("read in run");

   property p_doneblock;
      @(posedge clk) disable iff (rst)
      q.st == fpe_pkg::FPE_DONE |=> !flash_read_ok;
   endproperty
   a_doneblock: assert property (p_doneblock)
      else $error("no block");

   property p_runlen;
      @(posedge clk) disable iff (rst)
      $rose(pe_busy) |-> pe_busy [*8];
   endproperty
   a_runlen: assert property (p_runlen) else $error("run short");

   property p_dl;
      @(posedge clk) disable iff (rst)
      q.st == fpe_pkg::FPE_DOWNLOAD |-> ##[1:8] q.dl_done;
   endproperty
   a_dl: assert property (p_dl) else $error("download stuck");

   property p_switch;
      @(posedge clk) disable iff (rst)
      $rose(q.st == fpe_pkg::FPE_SWITCH) |-> !flash_read_ok [*4];
   endproperty
   a_switch: assert property (p_switch)
      else $error("switch access");

   property p_bootlock;
      @(posedge clk) disable iff (rst)
      map_boot |-> !(next_q.st == fpe_pkg::FPE_RUN);
   endproperty
   a_bootlock: assert property (p_bootlock)
      else $error("boot altered");

   property p_ptr;
      @(posedge clk) disable iff (rst)
      (q.st == fpe_pkg::FPE_IDLE && wr && addr == fpe_pkg::OFS_CCS &&
       wdata[fpe_pkg::CCS_GO] && !wdata[fpe_pkg::CCS_TRIG] &&
       !wdata[fpe_pkg::CCS_ERASE] && q.pdp[7]) |=> !pe_busy;
   endproperty
   a_ptr: assert property (p_ptr) else $error("ptr err");

   c_run: cover property (@(posedge clk) $rose(pe_busy));
   c_dl: cover property (@(posedge clk) $rose(q.dl_done));
   c_sw: cover property (@(posedge clk) $rose(q.st == fpe_pkg::FPE_SWITCH));
endmodule
`default_nettype wire

// ===== test/fpe_cpu_model.sv
// cpu side model: user procedure program on the register port
`timescale 1ns/1ns
`default_nettype none
module fpe_cpu_model (
   // clock
   input wire logic clk,
   // register port
   output logic [3:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [7:0] rdata,
   // interrupt line and reset pin
   output logic irq_req,
   output logic chip_init_pin_n
);
   initial begin
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      irq_req = 1'b0;
      // pin never pulled low mid-operation
      chip_init_pin_n = 1'b1;
   end
   // one-cycle write strobe, no wait states
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   // reset pin copy held low for n cycles
   task automatic pulse_pin(input int n);
      @(posedge clk);
      chip_init_pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      chip_init_pin_n <= 1'b1;
   endtask
   task automatic set_irq(input logic v);
      @(posedge clk);
      irq_req <= v;
   endtask
   // key before any run, cleared after
   // routine at target, entries at +16 and +32, stack 128
   // download once then alternate
   task automatic start_op(input logic [7:0] k, p, c);
      wr_reg(fpe_pkg::OFS_KEY, k);
      wr_reg(fpe_pkg::OFS_PDP, p);
      wr_reg(fpe_pkg::OFS_CCS, c);
   endtask
endmodule
`default_nettype wire

// ===== test/fpe_ctrl_test.sv
// self-checking bench for the flash program/erase control block
`timescale 1ns/1ns
`default_nettype none
module fpe_ctrl_test;
   logic clk, rst, wr, rd, irq_req, irq_accept, chip_init_pin_n;
   logic flash_read_ok, map_boot, pe_busy;
   logic [1:0] mode_pins;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, ram_load_addr, d;
   int errors = 0;
   int comparisons = 0;
   fpe_ctrl fpe_ctrl_i (.clk(clk), .rst(rst), .mode_pins(mode_pins),
      .chip_init_pin_n(chip_init_pin_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq_req(irq_req),
      .irq_accept(irq_accept), .flash_read_ok(flash_read_ok),
      .map_boot(map_boot), .ram_load_addr(ram_load_addr),
      .pe_busy(pe_busy));
   fpe_cpu_model fpe_cpu_model_i (.clk(clk), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq_req(irq_req),
      .chip_init_pin_n(chip_init_pin_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic summarize;
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic do_reset(input logic [1:0] m);
      @(posedge clk);
      rst <= 1'b1;
      mode_pins <= m;
      repeat (10) @(posedge clk);
      #1;
      chk("busy in reset", 8'h00, {7'h00, pe_busy});
      rst <= 1'b0;
   endtask
   task automatic t_boot_check;
      fpe_cpu_model_i.set_irq(1'b1);
      do_reset(fpe_pkg::MODE_USER_BOOT);
      repeat (4) @(posedge clk);
      #1;
      chk("irq in check", 8'h00, {7'h00, irq_accept});
      repeat (16) @(posedge clk);
      #1;
      chk("held irq", 8'h01, {7'h00, irq_accept});
      fpe_cpu_model_i.set_irq(1'b0);
      fpe_cpu_model_i.rd_reg(fpe_pkg::OFS_STAT, d);
      chk("user boot", 8'h01, {7'h00, d[fpe_pkg::ST_UBOOT]});
      chk("check flag", 8'h00, {7'h00, d[fpe_pkg::ST_CHECK]});
      fpe_cpu_model_i.rd_reg(fpe_pkg::OFS_SEL, d);
      chk("select", fpe_pkg::SEL_BOOT, d);
      chk("map boot", 8'h01, {7'h00, map_boot});
   endtask
   task automatic t_download;
      fpe_cpu_model_i.wr_reg(fpe_pkg::OFS_TGT, 8'h40);
      #1;
      chk("load addr", 8'h40, ram_load_addr);
      fpe_cpu_model_i.wr_reg(fpe_pkg::OFS_KEY, fpe_pkg::KEY_DL);
      fpe_cpu_model_i.wr_reg(fpe_pkg::OFS_CCS, 8'h01);
      repeat (fpe_pkg::DL_CYC + 2) @(posedge clk);
      fpe_cpu_model_i.rd_reg(fpe_pkg::OFS_STAT, d);
      chk("dl done", 8'h01, {7'h00, d[fpe_pkg::ST_DLDONE]});
   endtask
   // array switch: accesses and interrupts stall for its length
   task automatic t_switch(input logic [7:0] v, input logic m);
      fpe_cpu_model_i.set_irq(1'b1);
      fpe_cpu_model_i.wr_reg(fpe_pkg::OFS_SEL, v);
      #1;
      chk("irq in switch", 8'h00, {7'h00, irq_accept});
      fpe_cpu_model_i.rd_reg(fpe_pkg::OFS_STAT, d);
      chk("switching", 8'h01, {7'h00, d[fpe_pkg::ST_SWITCH]});
      repeat (fpe_pkg::SWITCH_CYC) @(posedge clk);
      #1;
      chk("map after switch", {7'h00, m}, {7'h00, map_boot});
      fpe_cpu_model_i.set_irq(1'b0);
   endtask
   task automatic t_op(input logic [7:0] k, p, c, e);
      int n;
      n = 0;
      fpe_cpu_model_i.start_op(k, p, c);
      #1;
      if (e === fpe_pkg::RET_OK) begin
         chk("read in run", 8'h00, {7'h00, flash_read_ok});
      end
      while (pe_busy !== 1'b0 && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (e === fpe_pkg::RET_OK && (n < 31 || n > 33)) begin
         chk("run length", 8'h20, n[7:0]);
      end
      fpe_cpu_model_i.rd_reg(fpe_pkg::OFS_RET, d);
      chk("return code", e, d);
      if (e === fpe_pkg::RET_OK) begin
         chk("read after run", 8'h00, {7'h00, flash_read_ok});
      end
      fpe_cpu_model_i.wr_reg(fpe_pkg::OFS_KEY, 8'h00);
      #1;
      chk("read key clear", 8'h01, {7'h00, flash_read_ok});
   endtask
   // a short low pulse is not a long reset, a long one is seen
   task automatic t_res_long;
      fpe_cpu_model_i.pulse_pin(20);
      repeat (4) @(posedge clk);
      fpe_cpu_model_i.rd_reg(fpe_pkg::OFS_STAT, d);
      chk("short low", 8'h00, {7'h00, d[fpe_pkg::ST_RESLONG]});
      fpe_cpu_model_i.pulse_pin(fpe_pkg::RES_LONG_CYC + 4);
      repeat (4) @(posedge clk);
      fpe_cpu_model_i.rd_reg(fpe_pkg::OFS_STAT, d);
      chk("long low", 8'h01, {7'h00, d[fpe_pkg::ST_RESLONG]});
   endtask
   task automatic t_user_prog;
      do_reset(fpe_pkg::MODE_USER_PROG);
      repeat (20) @(posedge clk);
      fpe_cpu_model_i.rd_reg(fpe_pkg::OFS_STAT, d);
      chk("no user boot", 8'h00, {7'h00, d[fpe_pkg::ST_UBOOT]});
      chk("main mapped", 8'h00, {7'h00, map_boot});
   endtask
   initial begin
      rst = 1'b1;
      mode_pins = fpe_pkg::MODE_USER_BOOT;
      t_boot_check();
      t_download();
      t_switch(fpe_pkg::SEL_MAIN, 1'b0);
      t_op(fpe_pkg::KEY_PE, 8'h10, 8'h06, fpe_pkg::RET_OK);
      t_op(fpe_pkg::KEY_PE, 8'h10, 8'h02, fpe_pkg::RET_OK);
      t_op(fpe_pkg::KEY_PE, 8'h80, 8'h02, fpe_pkg::RET_ERR_PTR);
      t_op(8'h00, 8'h10, 8'h02, fpe_pkg::RET_ERR_KEY);
      t_switch(fpe_pkg::SEL_BOOT, 1'b1);
      t_op(fpe_pkg::KEY_PE, 8'h10, 8'h02, fpe_pkg::RET_ERR_MAT);
      t_res_long();
      t_user_prog();
      summarize();
   end
   // the long pin pulse dominates at about 10,000 cycles; cut off well past
   initial begin
      #200000;
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
